// >>> dcsm_params.svh
// Purpose: constants shared by both ends of the column-command and strobe link
// Assumes: one data word per strobe edge, fixed two-beat bursts
// Notes:   DCSM_LINK_DIV counts cycles of CLK (125 MHz), DCSM_READ_LAT counts true_clock edges
`ifndef DCSM_PARAMS_SVH
`define DCSM_PARAMS_SVH

`define DCSM_DATA_W        16
`define DCSM_ADDR_W        8
`define DCSM_BANK_W        2
`define DCSM_MEM_DEPTH     256
`define DCSM_BURST_LEN     2
`define DCSM_LINK_DIV      4
`define DCSM_READ_LAT      4
`define DCSM_LANE0_LO      0
`define DCSM_LANE0_HI      7
`define DCSM_LANE1_LO      8
`define DCSM_LANE1_HI      15

`endif

// >>> dcsm_pkg.sv
// Purpose: types shared by both ends
// Assumes: command code is {cs_n, ras_n, cas_n, we_n}
// Notes:   codes follow the pin levels sampled at a true_clock rise
package dcsm_pkg;
    typedef enum logic [3:0] {
        DCSM_CMD_OPEN  = 4'h3,
        DCSM_CMD_PRE   = 4'h2,
        DCSM_CMD_READ  = 4'h5,
        DCSM_CMD_WRITE = 4'h4,
        DCSM_CMD_NOP   = 4'h7,
        DCSM_CMD_DESEL = 4'h8
    } dcsm_cmd_t;

    typedef enum logic [1:0] {
        DCSM_IDLE  = 2'b00,
        DCSM_WAIT  = 2'b01,
        DCSM_BURST = 2'b10
    } dcsm_state_t;
endpackage

// >>> dcsm_link_if.sv
// Purpose: pins between controller and memory end
// Assumes: two-way pins carried as in/out/enable, resolved here
// Notes:   data_lines and strobes are shared, one driver at a time
`timescale 1ns/100ps
interface dcsm_link_if;
    logic        true_clock;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank;
    logic [7:0]  addr;
    logic        lower_lane_mask;
    logic        upper_lane_mask;
    // controller drive
    logic [15:0] c_data_o;
    logic        c_data_oe;
    logic [1:0]  c_strobe_o;
    logic        c_strobe_oe;
    // memory drive
    logic [15:0] m_data_o;
    logic        m_data_oe;
    logic [1:0]  m_strobe_o;
    logic        m_strobe_oe;
    // resolved wire levels
    wire  [15:0] data_lines = m_data_oe ? m_data_o : (c_data_oe ? c_data_o : 16'h0000);
    wire  [1:0]  strobes    = m_strobe_oe ? m_strobe_o : (c_strobe_oe ? c_strobe_o : 2'h0);

    modport ctrl (output true_clock, cs_n, ras_n, cas_n, we_n, bank, addr,
                  lower_lane_mask, upper_lane_mask, c_data_o, c_data_oe,
                  c_strobe_o, c_strobe_oe, input data_lines, strobes);
    modport mem  (input true_clock, cs_n, ras_n, cas_n, we_n, bank, addr,
                  lower_lane_mask, upper_lane_mask, data_lines, strobes,
                  output m_data_o, m_data_oe, m_strobe_o, m_strobe_oe);
endinterface

// >>> dcsm_mem.sv
// Purpose: memory end: command decode, masked writes, strobed reads
// Assumes: true_clock and strobes sampled by CLK through two flops
// Notes:   write data captured on each strobe edge of the write burst
// Notes on behaviour
// - sample command pins on true_clock rise
// - cs low, ras high, cas low: column
// - we high reads, we low writes
// - we selects within both command pairs
// - cs, ras low, cas high: open/precharge
// - cs high ignores every command
// - memory drives strobes aligned with read data
// - controller strobes centre write data and masks
// - lower strobe bits 0-7, upper 8-15; this end writes both lanes on an edge of either strobe
// - masked byte leaves stored byte unchanged
// - lower mask bits 0-7, upper 8-15
// - data on both strobe edges
// - masks ignored during reads
`timescale 1ns/100ps
`include "dcsm_params.svh"
module dcsm_mem
    import dcsm_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // link
    dcsm_link_if.mem               LINK,
    // status
    output      logic [3:0]        BANK_OPEN,
    output      logic              BURST_BUSY
);
    logic [15:0] mem_q [0:`DCSM_MEM_DEPTH-1];
    logic [2:0]  tck_s_q;
    logic [1:0]  stb_a_q, stb_b_q, stb_c_q;
    logic [13:0] pin_a_q, pin_b_q;
    logic [17:0] wd_a_q, wd_b_q;
    logic [3:0]  cmd_q;
    logic [1:0]  bank_q;
    logic [7:0]  addr_q;
    logic [3:0]  open_q;
    logic        wr_act_q;
    logic [7:0]  wptr_q;
    logic [1:0]  wcnt_q;
    dcsm_state_t rst_q;
    logic [2:0]  rlat_q;
    logic [7:0]  rptr_q;
    logic [1:0]  rcnt_q;
    logic [15:0] dout_q;
    logic [1:0]  sout_q;
    logic        oe_q;

    // ------------------------------------------------------------
    // synchronisers and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        tck_s_q <= {tck_s_q[1:0], LINK.true_clock};
        stb_a_q <= LINK.strobes;
        stb_b_q <= stb_a_q;
        stb_c_q <= stb_b_q;
        // command, data and mask pins ride the same two-flop delay as their clocks
        pin_a_q <= {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n, LINK.bank, LINK.addr};
        pin_b_q <= pin_a_q;
        wd_a_q  <= {LINK.upper_lane_mask, LINK.lower_lane_mask, LINK.data_lines};
        wd_b_q  <= wd_a_q;
    end
    wire       tck_rise  = tck_s_q[1] & ~tck_s_q[2];
    wire       tck_fall  = ~tck_s_q[1] & tck_s_q[2];
    wire [1:0] stb_edge  = stb_b_q ^ stb_c_q;
    wire       beat      = stb_edge[0] | stb_edge[1];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire [3:0] cmd_pins  = pin_b_q[13:10];
    wire       selected  = ~cmd_q[3];
    wire       is_col    = selected & cmd_q[2] & ~cmd_q[1];
    wire       is_row    = selected & ~cmd_q[2] & cmd_q[1];
    wire       is_read   = is_col & cmd_q[0];
    wire       is_write  = is_col & ~cmd_q[0];
    wire       is_open   = is_row & cmd_q[0];
    wire       is_pre    = is_row & ~cmd_q[0];
    logic      cmd_new_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            cmd_q     <= DCSM_CMD_DESEL;
            cmd_new_q <= 1'b0;
        end else begin
            cmd_new_q <= tck_rise;
            if (tck_rise) begin
                cmd_q  <= cmd_pins;
                bank_q <= pin_b_q[9:8];
                addr_q <= pin_b_q[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // bank state
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            open_q <= 4'h0;
        end else if (cmd_new_q & is_open) begin
            open_q[bank_q] <= 1'b1;
        end else if (cmd_new_q & is_pre) begin
            open_q[bank_q] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write capture with byte masks
    // ------------------------------------------------------------
    wire [15:0] wdata = wd_b_q[15:0];
    wire        lmask = wd_b_q[16];
    wire        umask = wd_b_q[17];
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_act_q <= 1'b0;
            wcnt_q   <= 2'h0;
            wptr_q   <= 8'h00;
        end else if (cmd_new_q & is_write) begin
            wr_act_q <= 1'b1;
            wcnt_q   <= 2'h0;
            wptr_q   <= addr_q;
        end else if (wr_act_q & beat) begin
            if (!lmask)
                mem_q[wptr_q][`DCSM_LANE0_HI:`DCSM_LANE0_LO] <= wdata[7:0];
            if (!umask)
                mem_q[wptr_q][`DCSM_LANE1_HI:`DCSM_LANE1_LO] <= wdata[15:8];
            wptr_q <= wptr_q + 8'h01;
            wcnt_q <= wcnt_q + 2'h1;
            if (wcnt_q == 2'(`DCSM_BURST_LEN - 1))
                wr_act_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read burst: data and strobes change on true_clock edges
    // ------------------------------------------------------------
    wire tck_edge = tck_rise | tck_fall;
    always_ff @(posedge CLK) begin
        if (RST) begin
            rst_q  <= DCSM_IDLE;
            rlat_q <= 3'h0;
            rptr_q <= 8'h00;
            rcnt_q <= 2'h0;
            dout_q <= 16'h0000;
            sout_q <= 2'h0;
            oe_q   <= 1'b0;
        end else begin
            unique case (rst_q)
                DCSM_IDLE: begin
                    oe_q <= 1'b0;
                    if (cmd_new_q & is_read) begin
                        rst_q  <= DCSM_WAIT;
                        rlat_q <= 3'h0;
                        rptr_q <= addr_q;
                    end
                end
                DCSM_WAIT: begin
                    if (tck_edge) begin
                        rlat_q <= rlat_q + 3'h1;
                        if (rlat_q == 3'(`DCSM_READ_LAT - 2)) begin
                            oe_q   <= 1'b1;                  // preamble low
                            sout_q <= 2'h0;
                        end
                        if (rlat_q == 3'(`DCSM_READ_LAT - 1)) begin
                            rst_q  <= DCSM_BURST;
                            rcnt_q <= 2'h0;
                            dout_q <= mem_q[rptr_q];
                            sout_q <= 2'h3;
                            rptr_q <= rptr_q + 8'h01;
                        end
                    end
                end
                DCSM_BURST: begin
                    if (tck_edge) begin
                        rcnt_q <= rcnt_q + 2'h1;
                        if (rcnt_q == 2'(`DCSM_BURST_LEN - 1)) begin
                            rst_q  <= DCSM_IDLE;
                            oe_q   <= 1'b0;
                            sout_q <= 2'h0;
                        end else begin
                            dout_q <= mem_q[rptr_q];
                            sout_q <= ~sout_q;
                            rptr_q <= rptr_q + 8'h01;
                        end
                    end
                end
                default: rst_q <= DCSM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic       busy_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= wr_act_q | (rst_q != DCSM_IDLE);
        end
    end
    assign LINK.m_data_o    = dout_q;
    assign LINK.m_data_oe   = oe_q;
    assign LINK.m_strobe_o  = sout_q;
    assign LINK.m_strobe_oe = oe_q;
    assign BANK_OPEN        = open_q;
    assign BURST_BUSY       = busy_q;
endmodule // dcsm_mem

// >>> dcsm_ctrl.sv
// Purpose: controller end: makes true_clock, issues commands, strobes writes
// Assumes: one request at a time, user waits for READY
// Notes:   true_clock = CLK / DCSM_LINK_DIV, commands change on its fall
`timescale 1ns/100ps
`include "dcsm_params.svh"
module dcsm_ctrl
    import dcsm_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // user request
    input  wire logic              REQ_VALID,
    input  wire logic [3:0]        REQ_CMD,
    input  wire logic [1:0]        REQ_BANK,
    input  wire logic [7:0]        REQ_ADDR,
    input  wire logic [31:0]       REQ_WDATA,
    input  wire logic [3:0]        REQ_WMASK,
    // user answer
    output      logic              READY,
    output      logic              RD_VALID,
    output      logic [31:0]       RD_DATA,
    // link
    dcsm_link_if.ctrl              LINK
);
    logic [1:0]  div_q;
    logic        tck_q;
    logic [3:0]  cmd_q;
    logic [1:0]  bank_q;
    logic [7:0]  addr_q;
    logic        busy_q;
    logic [3:0]  phase_q;
    logic        is_wr_q, is_rd_q;
    logic [31:0] wbuf_q;
    logic [3:0]  mbuf_q;
    logic [15:0] dout_q;
    logic [1:0]  mout_q;
    logic [1:0]  sout_q;
    logic        oe_q, soe_q;
    logic [1:0]  sa_q, sb_q, sc_q;
    logic [15:0] da_q, db_q, dc_q;
    logic [31:0] rbuf_q;
    logic        rbeat_q, rvalid_q;

    // ------------------------------------------------------------
    // link clock divider
    // ------------------------------------------------------------
    wire tck_tog   = (div_q == 2'(`DCSM_LINK_DIV / 2 - 1));
    wire tck_fall  = tck_tog & tck_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_q <= 2'h0;
            tck_q <= 1'b0;
        end else begin
            div_q <= tck_tog ? 2'h0 : div_q + 2'h1;
            if (tck_tog)
                tck_q <= ~tck_q;
        end
    end

    // ------------------------------------------------------------
    // command issue, one true_clock period per command
    // ------------------------------------------------------------
    wire accept = REQ_VALID & ~busy_q & tck_fall;
    always_ff @(posedge CLK) begin
        if (RST) begin
            cmd_q   <= DCSM_CMD_DESEL;
            bank_q  <= 2'h0;
            addr_q  <= 8'h00;
            busy_q  <= 1'b0;
            phase_q <= 4'h0;
            is_wr_q <= 1'b0;
            is_rd_q <= 1'b0;
        end else if (accept) begin
            cmd_q   <= REQ_CMD;
            bank_q  <= REQ_BANK;
            addr_q  <= REQ_ADDR;
            wbuf_q  <= REQ_WDATA;
            mbuf_q  <= REQ_WMASK;
            busy_q  <= 1'b1;
            phase_q <= 4'h0;
            is_wr_q <= (REQ_CMD == DCSM_CMD_WRITE);
            is_rd_q <= (REQ_CMD == DCSM_CMD_READ);
        end else if (busy_q & tck_tog) begin
            cmd_q   <= tck_fall ? DCSM_CMD_NOP : cmd_q;
            phase_q <= phase_q + 4'h1;
            if (phase_q == 4'hB)
                busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write burst: strobe edges centred on data and masks
    // ------------------------------------------------------------
    wire half = (div_q == 2'h0);
    always_ff @(posedge CLK) begin
        if (RST) begin
            oe_q   <= 1'b0;
            soe_q  <= 1'b0;
            sout_q <= 2'h0;
            dout_q <= 16'h0000;
            mout_q <= 2'h0;
        end else if (is_wr_q & busy_q) begin
            if (tck_tog & (phase_q == 4'h1)) begin
                oe_q   <= 1'b1;
                soe_q  <= 1'b1;
                dout_q <= wbuf_q[15:0];
                mout_q <= mbuf_q[1:0];
            end
            if (tck_tog & (phase_q == 4'h2)) begin
                dout_q <= wbuf_q[31:16];
                mout_q <= mbuf_q[3:2];
            end
            if (tck_tog & (phase_q == 4'h3)) begin
                oe_q   <= 1'b0;
                soe_q  <= 1'b0;
            end
            if (half & oe_q)
                sout_q <= ~sout_q;
        end else begin
            oe_q   <= 1'b0;
            soe_q  <= 1'b0;
            sout_q <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // read capture on memory strobe edges
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        sa_q <= LINK.strobes;
        sb_q <= sa_q;
        sc_q <= sb_q;
        da_q <= LINK.data_lines;
        db_q <= da_q;
        dc_q <= db_q;
    end
    wire rd_edge = (sb_q[0] ^ sc_q[0]) & is_rd_q & busy_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            rbeat_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rbuf_q   <= 32'h0000_0000;
        end else begin
            rvalid_q <= 1'b0;
            if (accept) begin
                rbeat_q <= 1'b0;
            end else if (rd_edge) begin
                rbeat_q <= ~rbeat_q;
                if (rbeat_q) begin
                    rbuf_q[31:16] <= db_q;
                    rvalid_q      <= 1'b1;
                end else begin
                    rbuf_q[15:0]  <= db_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic ready_q;
    always_ff @(posedge CLK) begin
        if (RST)
            ready_q <= 1'b0;
        else
            ready_q <= ~busy_q & ~accept;
    end
    assign READY                = ready_q;
    assign RD_VALID             = rvalid_q;
    assign RD_DATA              = rbuf_q;
    assign LINK.true_clock      = tck_q;
    assign {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_q;
    assign LINK.bank            = bank_q;
    assign LINK.addr            = addr_q;
    assign LINK.lower_lane_mask = mout_q[0];
    assign LINK.upper_lane_mask = mout_q[1];
    assign LINK.c_data_o        = dout_q;
    assign LINK.c_data_oe       = oe_q;
    assign LINK.c_strobe_o      = sout_q;
    assign LINK.c_strobe_oe     = soe_q;
endmodule // dcsm_ctrl

// >>> dcsm_link_sva.sv
// Purpose: concurrent checks on the link between controller and memory end
// Assumes: every link signal sampled by CLK, true_clock rises found by a flop
// Notes:   instantiated beside the link interface in the bench
`timescale 1ns/100ps
module dcsm_link_sva
    import dcsm_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // command pins
    input wire logic        true_clock,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        lower_lane_mask,
    input wire logic        upper_lane_mask,
    // drive enables and resolved wires
    input wire logic        c_data_oe,
    input wire logic        c_strobe_oe,
    input wire logic        m_data_oe,
    input wire logic [1:0]  m_strobe_o,
    input wire logic        m_strobe_oe,
    input wire logic [1:0]  strobes,
    input wire logic [15:0] data_lines
);
    // ----------------------------------------
    // true_clock rise and command decode
    // ----------------------------------------
    logic       tc_q;
    wire        rise_w = true_clock & ~tc_q;
    wire  [3:0] cmd_w  = {cs_n, ras_n, cas_n, we_n};
    wire        rd_w   = rise_w && (cmd_w == DCSM_CMD_READ);
    wire        wr_w   = rise_w && (cmd_w == DCSM_CMD_WRITE);

    always_ff @(posedge CLK) begin
        tc_q <= true_clock;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    data_one_driver_a: assert property (!(c_data_oe && m_data_oe))
        else $error("both ends drive the data lines");
    strobe_one_driver_a: assert property (!(c_strobe_oe && m_strobe_oe))
        else $error("both ends drive the strobes");
    cmd_stable_rise_a: assert property (rise_w |-> $stable(cmd_w) ##1 $stable(cmd_w))
        else $error("command pins move at a true_clock rise");
    read_answer_a: assert property (rd_w |-> ##[2:40] m_data_oe)
        else $error("read command got no data from the memory end");
    read_ctrl_release_a: assert property (rd_w |-> !c_data_oe [*8])
        else $error("controller drives data after a read command");
    write_mem_quiet_a: assert property (wr_w |-> !m_data_oe [*8])
        else $error("memory end drives data after a write command");
    write_data_follows_a: assert property (wr_w |-> ##[2:40] (c_data_oe && c_strobe_oe))
        else $error("write command not followed by write data");
    read_strobe_data_a: assert property (m_strobe_oe |-> m_data_oe)
        else $error("read strobe driven without data");
    lanes_together_a: assert property (m_strobe_oe |-> m_strobe_o[0] == m_strobe_o[1])
        else $error("lane strobes differ during a read");
    write_edge_hold_a: assert property (c_strobe_oe && $past(c_strobe_oe)
        && $changed(strobes) |-> $stable(data_lines)
        && $stable({upper_lane_mask, lower_lane_mask}))
        else $error("write data or mask moves at a strobe edge");
endmodule // dcsm_link_sva

// >>> ddr_command_strobe_mask_port_tb.sv
// Purpose: drives the controller end against the memory end over the link
// Assumes: one request at a time, taken while READY is high
// Notes:   notes queued by the driver, compared by the watcher process
`timescale 1ns/100ps
module ddr_command_strobe_mask_port_tb
    import dcsm_pkg::*;
;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic        CLK, RST, REQ_VALID, READY, RD_VALID, BURST_BUSY;
    logic [3:0]  REQ_CMD, REQ_WMASK, BANK_OPEN, open_q;
    logic [1:0]  REQ_BANK, stb_q;
    logic [7:0]  REQ_ADDR;
    logic [31:0] REQ_WDATA, RD_DATA, seed, ref_q [256];
    logic [17:0] beat_q [$];
    logic [31:0] rd_q [$];
    int          n_fail, checks_done;

    dcsm_link_if link ();
    dcsm_ctrl dcsm_ctrl_inst (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD),
        .REQ_BANK(REQ_BANK), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
        .REQ_WMASK(REQ_WMASK), .READY(READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
        .LINK(link));
    dcsm_mem dcsm_mem_inst (.CLK(CLK), .RST(RST), .LINK(link), .BANK_OPEN(BANK_OPEN),
        .BURST_BUSY(BURST_BUSY));
    dcsm_link_sva dcsm_link_sva_inst (.CLK(CLK), .RST(RST), .true_clock(link.true_clock),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .lower_lane_mask(link.lower_lane_mask), .upper_lane_mask(link.upper_lane_mask),
        .c_data_oe(link.c_data_oe), .c_strobe_oe(link.c_strobe_oe),
        .m_data_oe(link.m_data_oe), .m_strobe_o(link.m_strobe_o),
        .m_strobe_oe(link.m_strobe_oe), .strobes(link.strobes), .data_lines(link.data_lines));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_lvl(input logic lvl);
        int n;
        n = 0;
        while (READY !== lvl && n < 300) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 300) begin
            n_fail++;
            summarize();
        end
    endtask

    // issue one request and note what the link and RD_DATA must show
    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] m);
        @(posedge CLK);
        wait_lvl(1'b1);
        if (c == DCSM_CMD_WRITE) begin
            beat_q.push_back({m[1:0], d[15:0]});
            beat_q.push_back({m[3:2], d[31:16]});
            for (int i = 0; i < 4; i++) if (!m[i]) ref_q[a][i*8 +: 8] = d[i*8 +: 8];
        end else if (c == DCSM_CMD_READ) begin
            beat_q.push_back({2'b00, ref_q[a][15:0]});
            beat_q.push_back({2'b00, ref_q[a][31:16]});
            rd_q.push_back(ref_q[a]);
        end
        REQ_VALID <= 1'b1;
        REQ_CMD   <= c;
        REQ_BANK  <= b;
        REQ_ADDR  <= a;
        REQ_WDATA <= d;
        REQ_WMASK <= m;
        @(posedge CLK);
        wait_lvl(1'b0);
        REQ_VALID <= 1'b0;
    endtask

    // ----------------------------------------
    // watcher: strobe edges on the wire, read answers
    // ----------------------------------------
    always @(posedge CLK) begin
        if (!RST && (link.c_strobe_oe || link.m_strobe_oe) && link.strobes !== stb_q) begin
            if (link.m_strobe_oe) check("BURST_BUSY", BURST_BUSY, 1);
            if (beat_q.size() == 0) check("unexpected beat", 1, 0);
            else check("beat", {link.c_strobe_oe ? {link.upper_lane_mask,
                link.lower_lane_mask} : 2'b00, link.data_lines}, beat_q.pop_front());
        end
        stb_q = link.strobes;
        if (!RST && RD_VALID === 1'b1) begin
            if (rd_q.size() == 0) check("unexpected read", 1, 0);
            else check("RD_DATA", RD_DATA, rd_q.pop_front());
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [3:0]  ign [3];
        logic [31:0] d;
        logic [7:0]  a;
        ign = '{4'hB, DCSM_CMD_DESEL, DCSM_CMD_NOP};
        n_fail = 0;
        checks_done = 0;
        seed = 32'hDE7D;
        stb_q = 2'h0;
        open_q = 4'h0;
        {REQ_VALID, REQ_CMD, REQ_BANK, REQ_ADDR, REQ_WDATA, REQ_WMASK} = '0;
        RST = 1'b1;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        check("BANK_OPEN reset", BANK_OPEN, 4'h0);
        for (int b = 0; b < 4; b++) begin
            op(DCSM_CMD_OPEN, b[1:0], 8'h00, 32'h0, 4'h0);
            wait_lvl(1'b1);
            open_q[b] = 1'b1;
            check("BANK_OPEN open", BANK_OPEN, open_q);
        end
        op(DCSM_CMD_PRE, 2'h2, 8'h00, 32'h0, 4'h0);
        wait_lvl(1'b1);
        open_q[2] = 1'b0;
        check("BANK_OPEN precharge", BANK_OPEN, open_q);
        foreach (ign[i]) begin
            op(ign[i], 2'h2, 8'h00, 32'h0, 4'h0);
            wait_lvl(1'b1);
            check("BANK_OPEN ignored", BANK_OPEN, open_q);
        end
        // every mask code, back to back: fill, masked write, read with masks set
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            a = {seed[2:0], k[3:0], 1'b0};
            seed = xs(seed);
            op(DCSM_CMD_WRITE, 2'h0, a, seed, 4'h0);
            seed = xs(seed);
            d = seed;
            op(DCSM_CMD_WRITE, 2'h0, a, d, k[3:0]);
            seed = xs(seed);
            op(DCSM_CMD_READ, 2'h0, a, 32'h0, seed[3:0] | 4'h1);
        end
        for (int n = 0; n < 300 && (rd_q.size() != 0 || beat_q.size() != 0); n++) begin
            @(posedge CLK);
        end
        check("notes left", rd_q.size() + beat_q.size(), 0);
        check("BURST_BUSY idle", BURST_BUSY, 0);
        summarize();
    end
endmodule // ddr_command_strobe_mask_port_tb
